// file: verilog/eprom_ctl.sv
// Host controller that reads, programs, erases and identifies the EPROM over its pins
// ============================================================================
// Device rules this block is written against
// RL1: Chip select high floats device data pins.
// RL2: Gate high with select floats data pins.
// RL3: Low program supply permits reads only.
// RL4: Ident voltage returns maker or part code.
// RL5: Command mode reads give array or identifiers.
// RL6: Command mode needs high program supply.
// RL7: Write strobe: address on fall, data rise.
// RL8: Command latch ignores the presented address.
// RL9: Standby and disable unchanged in command mode.
// RL10: Deselect does not abort running operations.
// RL11: Read command keeps array-read state.
// RL12: Device powers up in array read.
// RL13: Erase starts with set-up erase code.
// RL14: Second erase code starts bulk erase.
// RL15: Erase runs until verify strobe rises.
// RL16: Erase verify latches address, reads FFH.
// RL17: Verify upward, re-erase on any failure.
// RL18: Erase pulse at most 100 ms, 30 pulses.
// RL19: Set-up program, next strobe carries byte.
// RL20: Reset twice after set-up program.
// RL21: Program per byte, verify, 25 pulses max.
// RL22: Unknown code changes nothing.
// ============================================================================
`timescale 1ns/1ps
`default_nettype none

module eprom_ctl
  import eprom_ctl_pkg::*;
#(
  parameter int ERASE_PULSE_CYCLES = ERASE_PULSE_CYC,  // Shorten in simulation
  parameter int ERASE_PULSES = ERASE_MAX_PULSES,
  parameter int PROG_PULSES = PROG_MAX_PULSES
)(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic REQ_VALID,              // Request strobe, taken in idle
  input wire logic [2:0] REQ_OP,           // op_t code
  input wire logic [ADDR_W-1:0] REQ_ADDR,  // Byte address
  input wire logic [7:0] REQ_DATA,         // Byte to program
  output logic REQ_READY,                  // High in idle
  output logic DONE,                       // One-cycle completion pulse
  output logic FAIL,                       // Retry limit reached, with DONE
  output logic [7:0] RD_DATA,              // Byte read back
  output logic CHIP_SEL_N,
  output logic OUT_GATE_N,
  output logic WRITE_STROBE_N,
  output logic [ADDR_W-1:0] ADDR,
  output logic IDENT_SELECT_HV,            // Raise ident line to identifier voltage
  output logic PROGRAM_SUPPLY_HIGH,        // Raise program supply
  output logic [7:0] DATA_PINS_O,
  output logic DATA_PINS_OE,               // High while we drive the data pins
  input wire logic [7:0] DATA_PINS_I
);

  // ==========================================================================
  // State
  // ==========================================================================
  state_t state_reg, state_next;           // Sequencer state
  op_t op_reg;                             // Operation in progress
  logic [ADDR_W-1:0] addr_reg;             // Address on the pins
  logic [7:0] data_reg;                    // Data on the pins
  logic [7:0] wdata_reg;                   // Byte being programmed
  logic [2:0] step_reg;                    // Step inside the operation
  logic [5:0] pulses_reg;                  // Pulses used so far
  logic [31:0] cnt_reg;                    // Cycle timer
  logic [7:0] rd_reg;                      // Sampled byte
  logic done_reg, fail_reg;

  // Command byte written at a step; it is loaded as the strobe falls so that
  // it is already set up when the device takes it on the rise
  function automatic logic [7:0] step_command(input op_t op, input logic [2:0] step,
                                              input logic [7:0] wdata);
    logic [7:0] cmd;
    cmd = CMD_READ;
    case (op)
      OP_ERASE: cmd = (step == 3'h2) ? CMD_ERASE_VERIFY : CMD_SETUP_ERASE;  // see RL13
      OP_PROG: cmd = (step == 3'h0) ? CMD_SETUP_PROG :
                     (step == 3'h1) ? wdata : CMD_PROG_VERIFY;  // see RL19
      OP_RESET: cmd = CMD_RESET;  // Written twice, see RL20
      default: cmd = CMD_READ;
    endcase
    return cmd;
  endfunction : step_command

  // Wait length for each step, decoded continuously
  logic [31:0] wait_cyc;
  logic timer_done;
  assign timer_done = (cnt_reg == 32'h0);

  // Step sequences: erase 0:20 1:20(pulse) 2:A0 verify; program 0:40 1:data(pulse)
  // 2:C0 verify; reset 0:FF 1:FF; read/ident go straight to the read phase
  always_comb
  begin
    wait_cyc = 32'(RECOVERY_CYC);
    case (op_reg)
      // Pulse runs rise to rise, so strobe times come off the wait, see RL18
      // Limitation: the pulse length must exceed the strobe overhead
      OP_ERASE:
        if (step_reg == 3'h1)
          wait_cyc = 32'(ERASE_PULSE_CYCLES) - 32'(STROBE_HIGH_CYC + STROBE_LOW_CYC + 1);
      OP_PROG:
        if (step_reg == 3'h1)
          wait_cyc = 32'(PROG_PULSE_CYC);       // see RL21
      default: wait_cyc = 32'(RECOVERY_CYC);
    endcase
  end

  // Whether the current step ends with a read, and whether a write is last
  logic step_reads, step_last_write, rd_again;
  assign step_reads = (op_reg == OP_READ) || (op_reg == OP_IDENT) || (step_reg == 3'h2);
  assign step_last_write = (op_reg == OP_RESET) && (step_reg == 3'h1);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (REQ_VALID) state_next = (REQ_OP == OP_READ || REQ_OP == OP_IDENT) ? ST_RD : ST_WR_LOW;
      ST_WR_LOW: if (timer_done) state_next = ST_WR_HIGH;
      ST_WR_HIGH: if (timer_done) state_next = ST_WAIT;
      ST_WAIT: if (timer_done) state_next = (step_reads) ? ST_RD : (step_last_write ? ST_DONE : ST_WR_LOW);
      ST_RD: if (timer_done) state_next = rd_again ? ST_WR_LOW : ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Verify outcome of the byte just sampled
  logic verify_ok, retries_left, more_addr;
  assign verify_ok = (op_reg == OP_ERASE) ? (DATA_PINS_I == ERASED_BYTE) : (DATA_PINS_I == wdata_reg);
  assign retries_left = (op_reg == OP_ERASE) ? (32'(pulses_reg) < 32'(ERASE_PULSES)) :
                        (32'(pulses_reg) < 32'(PROG_PULSES));
  assign more_addr = (op_reg == OP_ERASE) && (addr_reg != {ADDR_W{1'b1}});
  // Pass with bytes left, or fail with pulses left, loops back to a write
  assign rd_again = ((op_reg == OP_ERASE) || (op_reg == OP_PROG))
                    && ((verify_ok && more_addr) || (!verify_ok && retries_left));

  // ==========================================================================
  // Sequencer registers
  // ==========================================================================
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= ST_IDLE;
      op_reg <= OP_READ;
      addr_reg <= '0;
      data_reg <= 8'h00;
      wdata_reg <= 8'h00;
      step_reg <= 3'h0;
      pulses_reg <= 6'h00;
      cnt_reg <= 32'h0;
      rd_reg <= 8'h00;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      done_reg <= 1'b0;
      if (!timer_done)
        cnt_reg <= cnt_reg - 32'h1;
      case (state_reg)
        ST_IDLE:
        begin
          if (REQ_VALID)
          begin
            op_reg <= op_t'(REQ_OP);
            // Erase verify walks upward from the lowest address, see RL17
            addr_reg <= (op_t'(REQ_OP) == OP_ERASE) ? '0 : REQ_ADDR;
            wdata_reg <= REQ_DATA;
            data_reg <= step_command(op_t'(REQ_OP), 3'h0, REQ_DATA);  // First command byte
            step_reg <= 3'h0;
            pulses_reg <= 6'h00;
            fail_reg <= 1'b0;
            cnt_reg <= 32'(STROBE_LOW_CYC) - 32'h1;
            if (op_t'(REQ_OP) == OP_READ || op_t'(REQ_OP) == OP_IDENT)
              cnt_reg <= 32'(ACCESS_CYC);
          end
        end
        ST_WR_LOW:
          if (timer_done)
          begin
            cnt_reg <= 32'(STROBE_HIGH_CYC) - 32'h1;
            if (step_reg == 3'h1 && op_reg != OP_RESET)
              pulses_reg <= pulses_reg + 6'h01;   // Counts each erase or program pulse
          end
        ST_WR_HIGH:
          if (timer_done)
            cnt_reg <= wait_cyc;   // Erase runs until the verify strobe rises, see RL15
        ST_WAIT:
          if (timer_done)
          begin
            step_reg <= step_reg + 3'h1;
            data_reg <= step_command(op_reg, step_reg + 3'h1, wdata_reg);
            cnt_reg <= step_reads ? 32'(ACCESS_CYC) : 32'(STROBE_LOW_CYC) - 32'h1;
          end
        ST_RD:
          if (timer_done)
          begin
            rd_reg <= DATA_PINS_I;
            if (op_reg == OP_ERASE || op_reg == OP_PROG)
            begin
              if (verify_ok && more_addr)
              begin
                addr_reg <= addr_reg + ADDR_W'(1);    // Next byte upward, see RL17
                step_reg <= 3'h2;
                data_reg <= step_command(op_reg, 3'h2, wdata_reg);
                cnt_reg <= 32'(STROBE_LOW_CYC) - 32'h1;
              end
              else if (!verify_ok && retries_left)
              begin
                step_reg <= 3'h0;                     // Re-erase or re-pulse, see RL17
                data_reg <= step_command(op_reg, 3'h0, wdata_reg);
                cnt_reg <= 32'(STROBE_LOW_CYC) - 32'h1;
              end
              else
                fail_reg <= !verify_ok;               // Stop after the ceiling, see RL18
            end
          end
        ST_DONE: done_reg <= 1'b1;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Pin drive
  // ==========================================================================
  logic writing;
  assign writing = (state_reg == ST_WR_LOW) || (state_reg == ST_WR_HIGH);
  // Supply raised for every command sequence; reads of the plain kind keep it low, see RL3
  assign PROGRAM_SUPPLY_HIGH = (op_reg != OP_READ) && (op_reg != OP_IDENT)
                               && (state_reg != ST_IDLE);  // see RL6
  assign IDENT_SELECT_HV = (op_reg == OP_IDENT) && (state_reg == ST_RD);  // see RL4
  assign CHIP_SEL_N = !(writing || state_reg == ST_RD);    // Select only while busy, see RL1
  assign OUT_GATE_N = (state_reg != ST_RD);                // Gate never low while we drive
  assign WRITE_STROBE_N = (state_reg != ST_WR_LOW);        // Strobe under select, see RL7
  assign ADDR = (op_reg == OP_IDENT) ? {{(ADDR_W-1){1'b0}}, addr_reg[0]} : addr_reg;
  assign DATA_PINS_O = data_reg;
  // Driven through the whole strobe, for setup before and hold after the rise, see RL7
  assign DATA_PINS_OE = writing;
  assign REQ_READY = (state_reg == ST_IDLE);
  assign DONE = done_reg;
  assign FAIL = fail_reg;
  assign RD_DATA = rd_reg;

endmodule : eprom_ctl

`default_nettype wire

// file: include/eprom_ctl_pkg.sv
// Package of command codes, timing counts and states for the EPROM bus controller
package eprom_ctl_pkg;

  // ==========================================================================
  // Command codes written to the device's command latch
  // ==========================================================================
  localparam logic [7:0] CMD_READ = 8'h00;          // Array read
  localparam logic [7:0] CMD_SETUP_ERASE = 8'h20;   // Set-up erase, twice to erase
  localparam logic [7:0] CMD_SETUP_PROG = 8'h40;    // Set-up program
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;  // Erase verify
  localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;   // Program verify
  localparam logic [7:0] CMD_RESET = 8'hFF;         // Reset, also null program data
  localparam logic [7:0] ERASED_BYTE = 8'hFF;       // Value of a fully erased byte

  // ==========================================================================
  // Geometry and retry limits
  // ==========================================================================
  localparam int ADDR_W = 17;                       // 128K bytes
  localparam int ERASE_MAX_PULSES = 30;             // Erase pulse ceiling
  localparam int PROG_MAX_PULSES = 25;              // Program pulses per byte

  // ==========================================================================
  // Timing, figures as printed and counts derived at the clock rate
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;                // 25 MHz core clock
  localparam int ERASE_PULSE_MS = 100;              // Longest erase pulse
  localparam int PROG_PULSE_US = 10;                // Program pulse length
  localparam int WRITE_RECOVERY_US = 6;             // Strobe high to read
  localparam int STROBE_LOW_NS = 50;                // Least strobe low time
  localparam int STROBE_HIGH_NS = 20;               // Least strobe high time
  localparam int ACCESS_NS = 150;                   // Slowest grade access time
  // Longest time rounds down, least times round up
  localparam int ERASE_PULSE_CYC = (ERASE_PULSE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int PROG_PULSE_CYC = (PROG_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = (WRITE_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Controller sequencer states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,      // Waiting for a request
    ST_WR_LOW = 4'b0001,    // Strobe low, address held
    ST_WR_HIGH = 4'b0010,   // Strobe released, data held
    ST_WAIT = 4'b0011,      // Pulse or recovery wait
    ST_RD = 4'b0100,        // Select and gate asserted, sampling
    ST_DONE = 4'b0101       // Report result
  } state_t;

  // Operation being sequenced
  typedef enum logic [2:0] {
    OP_READ = 3'b000,       // Plain array read
    OP_ERASE = 3'b001,      // Full erase with verify loop
    OP_PROG = 3'b010,       // One byte with verify loop
    OP_IDENT = 3'b011,      // Identifier read
    OP_RESET = 3'b100       // Double reset
  } op_t;

endpackage : eprom_ctl_pkg

// file: testbench/eprom_ctl_monitor.sv
// Checker of the EPROM controller's pin sequencing
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Pin timing and handshake checks
module eprom_ctl_monitor (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic DONE,
  input wire logic FAIL,
  input wire logic CHIP_SEL_N,
  input wire logic OUT_GATE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [16:0] ADDR,
  input wire logic IDENT_SELECT_HV,
  input wire logic PROGRAM_SUPPLY_HIGH,
  input wire logic DATA_PINS_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_strobe_sel: assert property (!WRITE_STROBE_N |-> !CHIP_SEL_N)
    else $error("strobe low while deselected");
  a_strobe_width: assert property ($fell(WRITE_STROBE_N) |-> ##1 !WRITE_STROBE_N ##1 WRITE_STROBE_N)
    else $error("strobe low time is not two cycles");
  a_addr_held: assert property (!WRITE_STROBE_N && !$past(WRITE_STROBE_N) |-> $stable(ADDR))
    else $error("address moved under strobe");
  a_data_at_rise: assert property ($rose(WRITE_STROBE_N) |-> DATA_PINS_OE)
    else $error("data not driven at strobe rise");
  a_data_setup: assert property ($fell(WRITE_STROBE_N) |-> DATA_PINS_OE)
    else $error("data not driven at strobe fall");
  a_write_supply: assert property (!WRITE_STROBE_N |-> PROGRAM_SUPPLY_HIGH)
    else $error("write with low program supply");
  a_read_quiet: assert property (!OUT_GATE_N |-> !DATA_PINS_OE && WRITE_STROBE_N)
    else $error("contention while gate low");
  a_ident_supply: assert property (IDENT_SELECT_HV |-> !PROGRAM_SUPPLY_HIGH)
    else $error("identifier voltage with high supply");
  a_done_pulse: assert property (DONE |=> !DONE)
    else $error("completion longer than one cycle");
  a_fail_at_done: assert property ($rose(FAIL) |=> DONE)
    else $error("failure flag away from completion");
  a_idle_released: assert property (REQ_READY |-> CHIP_SEL_N && WRITE_STROBE_N && !DATA_PINS_OE)
    else $error("idle controller holds the bus");
  c_fail: cover property (DONE && FAIL);
  c_ident: cover property (IDENT_SELECT_HV && !OUT_GATE_N);
  c_write: cover property ($fell(WRITE_STROBE_N));
endmodule : eprom_ctl_monitor
bind eprom_ctl eprom_ctl_monitor u_mon (.CORE_CLK, .RST, .REQ_VALID, .REQ_READY, .DONE, .FAIL,
  .CHIP_SEL_N, .OUT_GATE_N, .WRITE_STROBE_N, .ADDR, .IDENT_SELECT_HV, .PROGRAM_SUPPLY_HIGH,
  .DATA_PINS_OE);
`default_nettype wire

// file: testbench/eprom_dev_model.sv
// Behavioural model of the EPROM device at the controller's pins
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Device pins, array and command state
module eprom_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A,  // Arbitrary identity value
  parameter logic [7:0] PART_CODE = 8'h3C    // Arbitrary identity value
)(
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic vpp_hi,
  input wire logic id_hv,
  input wire logic [16:0] addr,
  input wire logic [7:0] d_in,
  output logic [7:0] q,
  output logic q_en
);
  logic [7:0] mem [int];          // Sparse array, absent cells read erased
  logic [7:0] state_reg = 8'h00;  // Powers up in array read
  logic [16:0] a_lat;             // Address taken at strobe fall
  logic erasing = 1'b0;           // Bulk erase running
  logic prog_arm = 1'b0;          // Next strobe carries program data
  int erase_fails = 0;            // Pulses the bench wants to leave ineffective
  int n_erase = 0, n_prog = 0, n_reset = 0, last_verify = -1;
  // Drive only with select and gate low, in either mode
  assign q_en = !ce_n && !oe_n;
  // Polled, because the array sits in no sensitivity list
  always #1 q = (id_hv && !vpp_hi) ? (addr[0] ? PART_CODE : MAKER_CODE)
    : (mem.exists(addr) ? mem[addr] : 8'hFF);
  // Pins settle after the clock edge that moves the strobe, so look a step later
  always @(negedge we_n) #1 if (!ce_n) a_lat = addr;
  // Commands need high supply; the address plays no part in decoding
  always @(posedge we_n) #1
  if (!ce_n && vpp_hi)
  begin
    // Erase ends only at the next strobe, whatever select did
    if (erasing)
    begin
      if (erase_fails > 0) erase_fails--;
      else mem.delete();
      erasing = 1'b0;
    end
    if (prog_arm)
    begin
      mem[a_lat] = (mem.exists(a_lat) ? mem[a_lat] : 8'hFF) & d_in;
      n_prog++;
      prog_arm = 1'b0;
    end
    else
      case (d_in)
        8'h20:
        begin
          erasing = (state_reg == 8'h20);
          n_erase += erasing;
          state_reg = erasing ? 8'h21 : 8'h20;
        end
        8'h40:
        begin
          prog_arm = 1'b1;
          state_reg = d_in;
        end
        8'hA0:
        begin
          last_verify = a_lat;
          state_reg = d_in;
        end
        8'hFF:
        begin
          n_reset++;
          state_reg = 8'h00;
        end
        8'h00, 8'hC0: state_reg = d_in;
        default: ; // Unknown code changes nothing
      endcase
  end
endmodule : eprom_dev_model
`default_nettype wire

// file: testbench/eprom_ctl_tb.sv
// Self-checking bench of the EPROM controller against the device model
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench top, clock, bus resolution and scenarios
module eprom_ctl_tb;
  import eprom_ctl_pkg::*;
  logic CORE_CLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0;
  logic [2:0] REQ_OP = 3'h0;
  logic [ADDR_W-1:0] REQ_ADDR = '0;
  logic [7:0] REQ_DATA = 8'h00, last_q = 8'h00;
  wire logic REQ_READY, DONE, FAIL, CHIP_SEL_N, OUT_GATE_N, WRITE_STROBE_N, q_en;
  wire logic IDENT_SELECT_HV, PROGRAM_SUPPLY_HIGH, DATA_PINS_OE;
  wire logic [7:0] RD_DATA, DATA_PINS_O, DATA_PINS_I, q;
  wire logic [ADDR_W-1:0] ADDR;
  int n_mismatch = 0, n_checks = 0;
  // A released bus shows the inverse of its last value, never a held copy
  assign DATA_PINS_I = DATA_PINS_OE ? DATA_PINS_O : (q_en ? q : ~last_q);
  always #20 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) if (DATA_PINS_OE || q_en) last_q <= DATA_PINS_I;
  // Short erase pulse keeps the retry loops inside the run budget
  eprom_ctl #(.ERASE_PULSE_CYCLES(20)) DUT (.CORE_CLK, .RST, .REQ_VALID, .REQ_OP, .REQ_ADDR,
    .REQ_DATA, .REQ_READY, .DONE, .FAIL, .RD_DATA, .CHIP_SEL_N, .OUT_GATE_N, .WRITE_STROBE_N,
    .ADDR, .IDENT_SELECT_HV, .PROGRAM_SUPPLY_HIGH, .DATA_PINS_O, .DATA_PINS_OE, .DATA_PINS_I);
  eprom_dev_model dev (.ce_n(CHIP_SEL_N), .oe_n(OUT_GATE_N), .we_n(WRITE_STROBE_N),
    .vpp_hi(PROGRAM_SUPPLY_HIGH), .id_hv(IDENT_SELECT_HV), .addr(ADDR), .d_in(DATA_PINS_I),
    .q(q), .q_en(q_en));
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // One request; a zero bound returns without waiting for completion
  task automatic op(input logic [2:0] code, input logic [16:0] a, input logic [7:0] d, input int bound);
    int i;
    @(negedge CORE_CLK);
    REQ_OP = code;
    REQ_ADDR = a;
    REQ_DATA = d;
    REQ_VALID = 1'b1;
    @(negedge CORE_CLK);
    REQ_VALID = 1'b0;
    for (i = 0; i < bound && DONE !== 1'b1; i++) @(negedge CORE_CLK);
    if (bound > 0 && DONE !== 1'b1)
    begin
      n_mismatch++;
      conclude();
    end
  endtask : op
  task automatic t_read;
    dev.mem[17'h1ABCD] = 8'h96;
    op(3'd0, 17'h1ABCD, 8'h00, 100);
    check("read data", RD_DATA, 8'h96);
    check("read wrote", dev.n_reset + dev.n_prog + dev.n_erase, 0);
  endtask : t_read
  task automatic t_ident;
    for (int b = 0; b < 2; b++)
    begin
      op(3'd3, 17'(b), 8'h00, 100);
      check("ident code", RD_DATA, b ? dev.PART_CODE : dev.MAKER_CODE);
    end
  endtask : t_ident
  task automatic t_prog;
    dev.mem[6] = 8'h00;
    dev.n_prog = 0;
    op(3'd2, 17'h5, 8'hA5, 3000);
    check("programmed byte", dev.mem[5], 8'hA5);
    check("program pass", {FAIL, RD_DATA, 8'(dev.n_prog)}, {1'b0, 8'hA5, 8'h01});
    dev.n_prog = 0;
    op(3'd2, 17'h6, 8'h0F, 20000);
    check("program pulses", dev.n_prog, PROG_MAX_PULSES);
    check("program fail", FAIL, 1'b1);
  endtask : t_prog
  task automatic t_reset;
    dev.n_reset = 0;
    op(3'd4, 17'h0, 8'h00, 400);
    check("reset writes", dev.n_reset, 2);
    check("reset state", dev.state_reg, 8'h00);
  endtask : t_reset
  task automatic t_erase_fail;
    dev.mem[0] = 8'h00;
    dev.erase_fails = 1000;
    dev.n_erase = 0;
    op(3'd1, 17'h0, 8'h00, 30000);
    check("erase pulse limit", dev.n_erase, ERASE_MAX_PULSES);
    check("erase fail", FAIL, 1'b1);
  endtask : t_erase_fail
  // Two ineffective pulses, then the upward walk, cut by a mid-run reset
  task automatic t_erase_walk;
    dev.erase_fails = 2;
    dev.n_erase = 0;
    op(3'd1, 17'h0, 8'h00, 0);
    for (int i = 0; i < 5000 && dev.last_verify < 3; i++) @(negedge CORE_CLK);
    check("erase retries", dev.n_erase, 3);
    check("verify walk", dev.last_verify, 3);
    RST = 1'b1;
    @(negedge CORE_CLK);
    RST = 1'b0;
    check("idle after reset", {REQ_READY, CHIP_SEL_N, WRITE_STROBE_N}, 3'b111);
    op(OP_READ, 17'h6, 8'h00, 100);
    check("read after cut", RD_DATA, 8'hFF);
  endtask : t_erase_walk
  initial
  begin
    repeat (20) @(negedge CORE_CLK);
    RST = 1'b0;
    check("power up state", dev.state_reg, 8'h00);
    t_read();
    t_ident();
    t_prog();
    t_reset();
    t_erase_fail();
    t_erase_walk();
    conclude();
  end
endmodule : eprom_ctl_tb
`default_nettype wire
